// File: src/gpftc_pkg.sv
// Purpose: Shared constants of the output pin and queue threshold bank
// Assumes: Byte-wide serial register port, six-bit register addresses
// Notes:   All offsets and reset values live here; selector and threshold fields are cut in the top module
package gpftc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [5:0] ADDR_OUT2_CFG  = 6'h00;
  localparam logic [5:0] ADDR_OUT1_CFG  = 6'h01;
  localparam logic [5:0] ADDR_OUT0_CFG  = 6'h02;
  localparam logic [5:0] ADDR_QUEUE_FILL_THRESHOLD  = 6'h03;
  localparam logic [5:0] ADDR_LAST_CFG  = 6'h03;
  localparam logic [5:0] ADDR_STROBE_LO = 6'h30;
  localparam logic [5:0] ADDR_STROBE_HI = 6'h3D;
  localparam logic [5:0] ADDR_PWR_TABLE = 6'h3E;
  localparam logic [5:0] ADDR_FIFO_DATA = 6'h3F;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_OUT2_CFG = 8'h29;
  localparam logic [7:0] RST_OUT1_CFG = 8'h2E;
  localparam logic [7:0] RST_OUT0_CFG = 8'h3F;
  localparam logic [7:0] RST_QUEUE_FILL_THRESHOLD = 8'h07;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int HDR_READ_BIT  = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam int CFG_INV_BIT   = 6;
  localparam int CFG_TOP_BIT   = 7;
  localparam int WAKE_SEL_BIT  = 6;
  localparam int ATTEN_LSB     = 4;
  localparam logic [7:0] OUT2_WR_MASK = 8'h7F;

  ////////////////////////////////////////////////////////////////////////
  // Signal selector codes and threshold arithmetic
  localparam logic [5:0] SEL_THREE_STATE = 6'h2E;
  localparam logic [5:0] TX_THR_BASE     = 6'h3D;
  localparam logic [6:0] RX_THR_BASE     = 7'h04;

  ////////////////////////////////////////////////////////////////////////
  // Wake-up test register loads
  localparam logic [7:0] WAKE_T1_RET0 = 8'h31;
  localparam logic [7:0] WAKE_T2_RET0 = 8'h88;
  localparam logic [7:0] WAKE_T1_RET1 = 8'h35;
  localparam logic [7:0] WAKE_T2_RET1 = 8'h81;

  ////////////////////////////////////////////////////////////////////////
  // Serial transfer phases
  typedef enum logic [1:0] {
    GPFTC_IDLE,
    GPFTC_HEADER,
    GPFTC_LOAD,
    GPFTC_DATA
  } gpftc_state_t;

endpackage

// File: src/gpftc_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module gpftc_sync #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // Two stage capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// File: src/gpftc_top.sv
// Purpose: Output pin configuration and queue threshold register bank
// Assumes: Serial port pins are slow against clk (sclk below clk/8)
// Notes:   Serial mode 0, header byte then data bytes, msb first
`timescale 1ns/1ps
module gpftc_top
  import gpftc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial register port pins
  input  wire logic        spi_sclk,
  input  wire logic        spi_csn,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // Remaining address space outside this bank
  output logic [5:0]       ext_addr,
  output logic [7:0]       ext_wr_data,
  output logic             ext_wr_pulse,
  output logic             ext_rd_pulse,
  output logic             ext_burst,
  output logic             strobe_pulse,
  input  wire logic [7:0]  ext_rd_data,
  input  wire logic [7:0]  status_byte,
  // Sleep wake event and signal sources
  input  wire logic        wake_pulse,
  input  wire logic [63:0] signal_bus,
  // Output pins
  output logic [2:0]       out_pin,
  output logic [2:0]       out_pin_oe,
  // Configuration seen by the radio
  output logic             out_drive_high,
  output logic             temp_sensor_enable,
  output logic [1:0]       rx_attenuation,
  output logic [5:0]       tx_threshold_bytes,
  output logic [6:0]       rx_threshold_bytes,
  output logic [7:0]       internal_test_reg_one,
  output logic [7:0]       internal_test_reg_two
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sclk_s, csn_s, mosi_s;
  gpftc_sync #(.WIDTH(3), .RESET_VAL(3'h2)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({spi_sclk, spi_csn, spi_mosi}),
    .q     ({sclk_s, csn_s, mosi_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // State
  gpftc_state_t state_reg, state_next;
  logic       sclk_d_reg, sclk_d_next;
  logic       csn_d_reg, csn_d_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] tx_reg, tx_next;
  logic [5:0] addr_reg, addr_next;
  logic       read_reg, read_next;
  logic       burst_reg, burst_next;
  logic       done_reg, done_next;
  logic [7:0] cfg2_reg, cfg2_next;
  logic [7:0] cfg1_reg, cfg1_next;
  logic [7:0] cfg0_reg, cfg0_next;
  logic [7:0] thr_reg, thr_next;
  logic [7:0] t1_reg, t1_next;
  logic [7:0] t2_reg, t2_next;
  logic       wr_p_next, rd_p_next, stb_next;
  logic [7:0] wdata_next;
  logic [2:0] pin_next, oe_next;
  logic [5:0] txthr_next;
  logic [6:0] rxthr_next;
  logic       rise, fall, cs_fall, byte_done;
  logic [7:0] byte_in, rdata;
  logic [5:0] sel [3];
  logic [2:0] inv;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection and read mux
  always_comb begin
    rise      = sclk_s & ~sclk_d_reg;
    fall      = ~sclk_s & sclk_d_reg;
    cs_fall   = ~csn_s & csn_d_reg;
    byte_in   = {rx_reg[6:0], mosi_s};
    byte_done = rise && (bit_reg == 3'h7) && !csn_s;
    case (addr_reg)
      ADDR_OUT2_CFG: rdata = cfg2_reg;
      ADDR_OUT1_CFG: rdata = cfg1_reg;
      ADDR_OUT0_CFG: rdata = cfg0_reg;
      ADDR_QUEUE_FILL_THRESHOLD: rdata = thr_reg;
      default:       rdata = ext_rd_data;  // Status, table, queue
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial transfer and register writes
  always_comb begin
    state_next  = state_reg;
    sclk_d_next = sclk_s;
    csn_d_next  = csn_s;
    bit_next    = bit_reg;
    rx_next     = rx_reg;
    tx_next     = tx_reg;
    addr_next   = addr_reg;
    read_next   = read_reg;
    burst_next  = burst_reg;
    done_next   = done_reg;
    cfg2_next   = cfg2_reg;   // Only rst_n or a write changes these
    cfg1_next   = cfg1_reg;
    cfg0_next   = cfg0_reg;
    thr_next    = thr_reg;
    wr_p_next   = 1'b0;
    rd_p_next   = 1'b0;
    stb_next    = 1'b0;
    wdata_next  = ext_wr_data;
    if (rise) begin
      rx_next  = byte_in;
      bit_next = bit_reg + 3'h1;
    end
    if (fall && bit_reg != 3'h0) begin
      tx_next = {tx_reg[6:0], 1'b0};  // Next bit out
    end
    case (state_reg)
      GPFTC_IDLE: begin
        bit_next = 3'h0;
        if (cs_fall) begin
          tx_next    = status_byte;
          state_next = GPFTC_HEADER;
        end
      end
      GPFTC_HEADER: begin
        if (byte_done) begin
          addr_next  = byte_in[5:0];
          read_next  = byte_in[HDR_READ_BIT];
          burst_next = byte_in[HDR_BURST_BIT];
          done_next  = 1'b0;
          if (!byte_in[HDR_BURST_BIT] && byte_in[5:0] >= ADDR_STROBE_LO
              && byte_in[5:0] <= ADDR_STROBE_HI) begin
            stb_next   = 1'b1;
            done_next  = 1'b1;
            tx_next    = status_byte;
            state_next = GPFTC_DATA;
          end else if (byte_in[HDR_READ_BIT]) begin
            state_next = GPFTC_LOAD;
          end else begin
            state_next = GPFTC_DATA;
          end
        end
      end
      GPFTC_LOAD: begin
        // Present read data, then step the address for a burst
        tx_next    = rdata;
        rd_p_next  = 1'b1;
        state_next = GPFTC_DATA;
        if (burst_reg && addr_reg < ADDR_PWR_TABLE) begin
          addr_next = addr_reg + 6'h01;
        end
        done_next  = !burst_reg;  // Single read stops after one byte
      end
      GPFTC_DATA: begin
        if (byte_done && read_reg && !done_reg) begin
          state_next = GPFTC_LOAD;
        end else if (byte_done && !done_reg) begin
          tx_next   = status_byte;
          done_next = !burst_reg;
          case (addr_reg)
            ADDR_OUT2_CFG: cfg2_next = byte_in & OUT2_WR_MASK;
            ADDR_OUT1_CFG: cfg1_next = byte_in;
            ADDR_OUT0_CFG: cfg0_next = byte_in;
            ADDR_QUEUE_FILL_THRESHOLD: thr_next  = byte_in;
            default: begin
              wr_p_next  = 1'b1;
              wdata_next = byte_in;
            end
          endcase
          if (addr_reg < ADDR_PWR_TABLE) begin
            addr_next = addr_reg + 6'h01;
          end
        end
      end
      default: state_next = GPFTC_IDLE;
    endcase
    if (csn_s) begin
      state_next = GPFTC_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin routing, thresholds and wake loads
  always_comb begin
    sel[2] = cfg2_reg[5:0];
    sel[1] = cfg1_reg[5:0];
    sel[0] = cfg0_reg[5:0];
    inv    = {cfg2_reg[CFG_INV_BIT], cfg1_reg[CFG_INV_BIT],
              cfg0_reg[CFG_INV_BIT]};
    for (int i = 0; i < 3; i++) begin
      pin_next[i] = signal_bus[sel[i]] ^ inv[i];
      oe_next[i]  = (sel[i] != SEL_THREE_STATE);
    end
    if (cfg0_reg[CFG_TOP_BIT]) begin
      oe_next[0] = 1'b0;  // Pin 0 carries the analog sensor
    end
    txthr_next = TX_THR_BASE - {thr_reg[3:0], 2'b00};
    rxthr_next = RX_THR_BASE + {1'b0, thr_reg[3:0], 2'b00};
    t1_next    = t1_reg;
    t2_next    = t2_reg;
    if (wake_pulse && thr_reg[WAKE_SEL_BIT]) begin
      t1_next = WAKE_T1_RET1;
      t2_next = WAKE_T2_RET1;
    end else if (wake_pulse) begin
      t1_next = WAKE_T1_RET0;
      t2_next = WAKE_T2_RET0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg             <= GPFTC_IDLE;
      sclk_d_reg            <= 1'b0;
      csn_d_reg             <= 1'b1;
      bit_reg               <= 3'h0;
      rx_reg                <= 8'h00;
      tx_reg                <= 8'h00;
      addr_reg              <= 6'h00;
      read_reg              <= 1'b0;
      burst_reg             <= 1'b0;
      done_reg              <= 1'b0;
      cfg2_reg              <= RST_OUT2_CFG;
      cfg1_reg              <= RST_OUT1_CFG;
      cfg0_reg              <= RST_OUT0_CFG;
      thr_reg               <= RST_QUEUE_FILL_THRESHOLD;
      t1_reg                <= WAKE_T1_RET0;
      t2_reg                <= WAKE_T2_RET0;
      spi_miso              <= 1'b0;
      spi_miso_oe           <= 1'b0;
      ext_wr_data           <= 8'h00;
      ext_wr_pulse          <= 1'b0;
      ext_rd_pulse          <= 1'b0;
      strobe_pulse          <= 1'b0;
      out_pin               <= 3'h0;
      out_pin_oe            <= 3'h0;
      tx_threshold_bytes    <= 6'h00;
      rx_threshold_bytes    <= 7'h00;
      ext_addr              <= 6'h00;
    end else begin
      state_reg             <= state_next;
      sclk_d_reg            <= sclk_d_next;
      csn_d_reg             <= csn_d_next;
      bit_reg               <= bit_next;
      rx_reg                <= rx_next;
      tx_reg                <= tx_next;
      addr_reg              <= addr_next;
      read_reg              <= read_next;
      burst_reg             <= burst_next;
      done_reg              <= done_next;
      cfg2_reg              <= cfg2_next;
      cfg1_reg              <= cfg1_next;
      cfg0_reg              <= cfg0_next;
      thr_reg               <= thr_next;
      t1_reg                <= t1_next;
      t2_reg                <= t2_next;
      spi_miso              <= tx_next[7];
      spi_miso_oe           <= ~csn_s;
      ext_wr_data           <= wdata_next;
      ext_wr_pulse          <= wr_p_next;
      ext_rd_pulse          <= rd_p_next;
      strobe_pulse          <= stb_next;
      out_pin               <= pin_next;
      out_pin_oe            <= oe_next;
      tx_threshold_bytes    <= txthr_next;
      rx_threshold_bytes    <= rxthr_next;
      ext_addr              <= (wr_p_next | rd_p_next) ? addr_reg : addr_next;
    end
  end
  // Straight register views
  assign ext_burst             = burst_reg;
  assign out_drive_high        = cfg1_reg[CFG_TOP_BIT];
  assign temp_sensor_enable    = cfg0_reg[CFG_TOP_BIT];
  assign rx_attenuation        = thr_reg[ATTEN_LSB +: 2];
  assign internal_test_reg_one = t1_reg;
  assign internal_test_reg_two = t2_reg;
endmodule

// File: verif/gpftc_sva.sv
// Purpose: Port assertions for the pin and threshold bank
// Assumes: Sees only gpftc_top ports
// Notes:   Bound below the module
`timescale 1ns/1ps
module gpftc_sva (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Serial and outer address space
  input wire logic       spi_csn,
  input wire logic       spi_miso_oe,
  input wire logic [5:0] ext_addr,
  input wire logic       ext_wr_pulse,
  input wire logic       ext_burst,
  input wire logic       strobe_pulse,
  input wire logic       wake_pulse,
  // Configuration outputs
  input wire logic [2:0] out_pin_oe,
  input wire logic       out_drive_high,
  input wire logic       temp_sensor_enable,
  input wire logic [1:0] rx_attenuation,
  input wire logic [5:0] tx_threshold_bytes,
  input wire logic [6:0] rx_threshold_bytes,
  input wire logic [7:0] internal_test_reg_one,
  input wire logic [7:0] internal_test_reg_two
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Threshold pair, reset view, wake loads
  thr_sum_a: assert property ($past(rst_n) |->
    7'(tx_threshold_bytes) + rx_threshold_bytes == 7'h41
    && tx_threshold_bytes[1:0] == 2'h1) else $error("threshold pair");
  reset_pins_a: assert property ($rose(rst_n) |=>
    out_pin_oe == 3'h5 && tx_threshold_bytes == 6'h21)
    else $error("reset view");
  wake_load_a: assert property (wake_pulse |=>
    internal_test_reg_one == 8'h35 && internal_test_reg_two == 8'h81 ||
    internal_test_reg_one == 8'h31 && internal_test_reg_two == 8'h88)
    else $error("wake load");
  test_hold_a: assert property (!wake_pulse |=>
    $stable(internal_test_reg_one) && $stable(internal_test_reg_two))
    else $error("test reg moved");
  wake_keep_a: assert property (wake_pulse |=>
    $stable(tx_threshold_bytes) && $stable(out_pin_oe))
    else $error("wake changed config");
  idle_keep_a: assert property (spi_csn [*8] |->
    $stable(out_drive_high) && $stable(temp_sensor_enable)
    && $stable(rx_attenuation)) else $error("config moved idle");

  ////////////////////////////////////////////////////////////////////////
  // Outer address space and serial output enable
  strobe_addr_a: assert property (strobe_pulse |-> !ext_burst &&
    ext_addr >= 6'h30 && ext_addr <= 6'h3D) else $error("strobe addr");
  strobe_once_a: assert property (strobe_pulse |=> !strobe_pulse)
    else $error("strobe long");
  wr_addr_a: assert property (ext_wr_pulse |-> ext_addr >= 6'h04 &&
    !(ext_addr <= 6'h3D && ext_addr >= 6'h30 && !ext_burst))
    else $error("outer write addr");
  miso_off_a: assert property (spi_csn [*6] |-> !spi_miso_oe)
    else $error("miso driven");
  miso_on_a: assert property (!spi_csn [*6] |-> spi_miso_oe)
    else $error("miso idle");

  // Main scenarios
  cover property (strobe_pulse);
  cover property (wake_pulse ##1 internal_test_reg_one == 8'h35);
  cover property (ext_wr_pulse && ext_burst);
endmodule

bind gpftc_top gpftc_sva i_gpftc_sva (
  .clk(clk), .rst_n(rst_n), .spi_csn(spi_csn),
  .spi_miso_oe(spi_miso_oe), .ext_addr(ext_addr),
  .ext_wr_pulse(ext_wr_pulse), .ext_burst(ext_burst),
  .strobe_pulse(strobe_pulse), .wake_pulse(wake_pulse),
  .out_pin_oe(out_pin_oe), .out_drive_high(out_drive_high),
  .temp_sensor_enable(temp_sensor_enable),
  .rx_attenuation(rx_attenuation),
  .tx_threshold_bytes(tx_threshold_bytes),
  .rx_threshold_bytes(rx_threshold_bytes),
  .internal_test_reg_one(internal_test_reg_one),
  .internal_test_reg_two(internal_test_reg_two));

// File: verif/gpftc_host.sv
// Purpose: Host side of the serial register port
// Assumes: Mode 0, sclk half period of eight clk cycles
// Notes:   Data line inverted when a frame closes
`timescale 1ns/1ps
module gpftc_host (
  // Clock
  input  wire logic clk,
  // Serial pins
  input  wire logic miso,
  output logic      sclk,
  output logic      csn,
  output logic      mosi
);
  localparam int HALF = 8;

  // Idle pins: clock still and low, device deselected
  initial begin
    sclk = 1'b0;
    csn  = 1'b1;
    mosi = 1'b0;
  end

  // Wait n edges, then step just past the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Select the device
  task automatic frame_open();
    csn = 1'b0;
    hold(HALF);
  endtask

  // One byte each way, msb first, reply taken at the rising edge
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      hold(HALF);
      sclk = 1'b1;
      rx[i] = miso;
      hold(HALF);
      sclk = 1'b0;
    end
  endtask

  // Deselect and invert the data line
  task automatic frame_close();
    hold(HALF);
    csn  = 1'b1;
    mosi = ~mosi;
    hold(HALF);
  endtask
endmodule

// File: verif/gpftc_top_test.sv
// Purpose: Self-checking bench of the pin and threshold bank
// Assumes: Host model drives the serial port
// Notes:   Outer read data fixed at 0xA5
`timescale 1ns/1ps
module gpftc_top_test;
  import gpftc_pkg::*;
  logic        clk, rst_n, sclk, csn, mosi, miso, wake, ext_wr, stb, temp;
  logic        oe, rdp, burst, drv;
  logic [1:0]  att;
  logic [63:0] sig;
  logic [5:0]  ext_addr, tx_thr, wr_a, rd_a;
  logic [6:0]  rx_thr;
  logic [2:0]  pin, pin_oe;
  logic [7:0]  t1, t2, x, wdat;
  int          mismatches, check_count, cycles, wr_n, stb_n, rd_n, k;

  gpftc_top i_gpftc_top (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk),
    .spi_csn(csn), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe),
    .ext_addr(ext_addr), .ext_wr_data(wdat), .ext_wr_pulse(ext_wr),
    .ext_rd_pulse(rdp), .ext_burst(burst), .strobe_pulse(stb),
    .ext_rd_data(8'hA5), .status_byte(8'h0F), .wake_pulse(wake),
    .signal_bus(sig), .out_pin(pin), .out_pin_oe(pin_oe),
    .out_drive_high(drv), .temp_sensor_enable(temp), .rx_attenuation(att),
    .tx_threshold_bytes(tx_thr), .rx_threshold_bytes(rx_thr),
    .internal_test_reg_one(t1), .internal_test_reg_two(t2));
  gpftc_host i_gpftc_host (.clk(clk), .miso(miso), .sclk(sclk),
    .csn(csn), .mosi(mosi));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Pulse counters and hang limit
  always @(posedge clk) begin
    cycles++;
    if (ext_wr) begin
      wr_n++;
      wr_a = ext_addr;
    end
    if (rdp) begin
      rd_n++;
      rd_a = ext_addr;
    end
    if (stb) stb_n++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Frame of a header and up to four bytes, read replies compared
  task automatic xfer(input logic [7:0] hdr, input int n,
                      input logic [31:0] d, input logic [31:0] e);
    i_gpftc_host.frame_open();
    i_gpftc_host.xbyte(hdr, x);
    for (int i = 0; i < n; i++) begin
      i_gpftc_host.xbyte(d[31-8*i -: 8], x);
      if (hdr[7]) check(x, e[31-8*i -: 8]);
    end
    i_gpftc_host.frame_close();
  endtask

  task automatic wake_chk(input logic [7:0] thr, input logic [15:0] e);
    xfer({2'h0, ADDR_QUEUE_FILL_THRESHOLD}, 1, {thr, 24'h0}, 32'h0);
    wake = 1'b1;
    i_gpftc_host.hold(1);
    wake = 1'b0;
    i_gpftc_host.hold(1);
    check(t1, e[15:8]);
    check(t2, e[7:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wake = 1'b0;
    sig = 64'h0;
    sig[41] = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    i_gpftc_host.hold(4);
    check({5'h0, pin_oe}, 8'h05);
    check({7'h0, pin[2]}, 8'h01);
    xfer(8'hC0, 4, 32'h0, 32'h292E3F07);
    xfer(8'h02, 1, 32'h2E000000, 32'h0);
    check({5'h0, pin_oe}, 8'h04);
    for (int n = 0; n < 16; n++) begin
      xfer(8'h03, 1, {8'(n), 24'h0}, 32'h0);
      check({2'h0, tx_thr}, 8'(61 - 4 * n));
      check({1'h0, rx_thr}, 8'(4 * n + 4));
    end
    sig = 64'h20;
    xfer(8'h40, 4, 32'hC585453F, 32'h0);
    check({5'h0, pin}, 8'h02);
    check({7'h0, drv}, 8'h01);
    check({6'h0, att}, 8'h03);
    sig = 64'h0;
    i_gpftc_host.hold(2);
    check({5'h0, pin}, 8'h05);
    xfer(8'hC0, 4, 32'h0, 32'h4585453F);
    xfer(8'h02, 1, 32'h80000000, 32'h0);
    check({7'h0, temp}, 8'h01);
    check({7'h0, pin_oe[0]}, 8'h00);
    wake_chk(8'h47, 16'h3581);
    wake_chk(8'h07, 16'h3188);
    xfer(8'hC0, 4, 32'h0, 32'h45858007);
    xfer(8'h36, 0, 32'h0, 32'h0);
    check(8'(stb_n), 8'h01);
    check({2'h0, ext_addr}, 8'h36);
    xfer(8'hF5, 1, 32'h0, 32'hA5000000);
    xfer(8'h7E, 2, 32'h11220000, 32'h0);
    check(8'(wr_n), 8'h02);
    check({2'h0, ext_addr}, 8'h3E);
    check(wdat, 8'h22);
    check({7'h0, burst}, 8'h01);
    xfer(8'h04, 1, 32'h5A000000, 32'h0);
    check({2'h0, wr_a}, 8'h04);
    check(wdat, 8'h5A);
    check(8'(stb_n), 8'h01);
    k = rd_n;
    xfer(8'hBF, 1, 32'h0, 32'hA5000000);
    check(8'(rd_n - k), 8'h01);
    check({2'h0, rd_a}, 8'h3F);
    report_and_stop();
  end
endmodule
